// ---- include/prog_map_defines.vh ----
// Constants for the program memory map and hard vectoring block
`ifndef PROG_MAP_DEFINES_VH
`define PROG_MAP_DEFINES_VH

`define PC_WIDTH          21
`define PC_RESET_VALUE    21'h000000
`define HIGH_IRQ_VECTOR   21'h000008
`define LOW_IRQ_VECTOR    21'h000018
`define PC_STEP           21'h000002
`define SMALL_TOP_BYTE    21'h00ffff
`define LARGE_TOP_BYTE    21'h01ffff
`define SMALL_WORD_BITS   15
`define LARGE_WORD_BITS   16
`define CONFIG_WORDS      4
`define CONFIG_WORD_BITS  2
`define STACK_PTR_WIDTH   5
`define STACK_PTR_RESET   5'h00
`define STACK_PTR_MAX     5'h1f
`define INSN_WIDTH        16

`endif

// ---- hdl/prog_flash_array.v ----
// On-chip program Flash word array with a separate fetch port
`timescale 1ns/1ps
`default_nettype none
`include "prog_map_defines.vh"

module prog_flash_array (
  // Clock
  input  wire                      clk_in,
  // Fetch port
  input  wire [`LARGE_WORD_BITS-1:0] word_addr_in,
  output reg  [`INSN_WIDTH-1:0]    word_out,
  // Programming port
  input  wire                      prog_we_in,
  input  wire [`LARGE_WORD_BITS-1:0] prog_addr_in,
  input  wire [`INSN_WIDTH-1:0]    prog_data_in
);

  reg [`INSN_WIDTH-1:0] mem [0:(1<<`LARGE_WORD_BITS)-1];

  always @(posedge clk_in) begin
    if (prog_we_in) begin
      mem[prog_addr_in] <= prog_data_in;
    end
    word_out <= mem[word_addr_in];
  end

endmodule
`default_nettype wire

// ---- hdl/program_memory_map_vectoring.v ----
// Program counter, program memory map, hard vectors and wake-up push
// Notes on behaviour
// - Program counter is 21 bits, byte addressed, over a 2 MB space.
// - Fetches above implemented memory return an all-zero word.
// - Every device reset loads the program counter with address zero.
// - High-priority vector is 0x0008, low-priority vector is 0x0018.
// - Interrupt wake-up with a global enable pushes the PC onto stack.
// - That wake-up then loads the matching priority vector into the PC.
// - Implemented memory is 64 KB or 128 KB by variant.
// - Fetch bus is separate from data bus; both may act per cycle.
// - Top four words hold configuration, copied out after every reset.
// - PC bit zero is always zero; sequential fetch adds two.
`timescale 1ns/1ps
`default_nettype none
`include "prog_map_defines.vh"

module program_memory_map_vectoring (
  // Clock and reset
  input  wire                       clk_in,
  input  wire                       srst_in,
  // Variant select: high selects the 128 KB part
  input  wire                       large_variant_in,
  // Core fetch control
  input  wire                       fetch_advance_in,
  input  wire                       pc_load_in,
  input  wire [`PC_WIDTH-1:0]       pc_load_value_in,
  // Wake-up from interrupt
  input  wire                       irq_wake_in,
  input  wire                       irq_high_in,
  input  wire                       high_priority_global_irq_enable_in,
  input  wire                       low_priority_global_irq_enable_in,
  // Flash programming port
  input  wire                       prog_we_in,
  input  wire [`LARGE_WORD_BITS-1:0] prog_addr_in,
  input  wire [`INSN_WIDTH-1:0]     prog_data_in,
  // Data space bus, independent of the fetch path
  input  wire                       data_req_in,
  output reg                        data_ack_out,
  // Fetch result
  output wire [`PC_WIDTH-1:0]       pc_out,
  output reg  [`INSN_WIDTH-1:0]     insn_out,
  output reg                        insn_valid_out,
  // Return stack top
  output reg  [`STACK_PTR_WIDTH-1:0] return_stack_pointer_out,
  output reg  [7:0]                 stack_top_upper_byte_out,
  output reg  [7:0]                 stack_top_high_byte_out,
  output reg  [7:0]                 stack_top_low_byte_out,
  output reg                        push_strobe_out,
  // Configuration copy
  output reg  [`INSN_WIDTH*`CONFIG_WORDS-1:0] config_data_out,
  output reg                        config_done_out
);

  // ------------------------------------------------------------
  // Program counter
  // ------------------------------------------------------------
  reg  [`PC_WIDTH-1:0] pc;
  reg  [`PC_WIDTH-1:0] next_pc;
  reg  [`CONFIG_WORD_BITS:0] cfg_step;
  wire                 cfg_busy;
  wire                 wake_vector;

  assign cfg_busy    = (cfg_step != {(`CONFIG_WORD_BITS+1){1'b0}});
  assign wake_vector = irq_wake_in &&
                       (high_priority_global_irq_enable_in ||
                        low_priority_global_irq_enable_in);
  assign pc_out      = pc;

  always @* begin
    next_pc = pc;
    if (wake_vector) begin
      next_pc = irq_high_in ? `HIGH_IRQ_VECTOR : `LOW_IRQ_VECTOR;
    end else if (pc_load_in) begin
      next_pc = pc_load_value_in;
    end else if (fetch_advance_in && !cfg_busy) begin
      next_pc = pc + `PC_STEP;
    end
    next_pc[0] = 1'b0;
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      pc <= `PC_RESET_VALUE;
    end else begin
      pc <= next_pc;
    end
  end

  // ------------------------------------------------------------
  // Memory map decode
  // ------------------------------------------------------------
  // Configuration copy borrows the fetch port for four cycles after
  // reset, so the core must not rely on fetch results until done.
  wire [`PC_WIDTH-1:0]   top_byte;
  wire [`PC_WIDTH-1:0]   cfg_byte;
  wire [`PC_WIDTH-1:0]   read_byte;
  wire                   implemented;
  reg                    implemented_q;
  reg                    fetch_q;
  wire [`INSN_WIDTH-1:0] flash_word;
  wire [`INSN_WIDTH-1:0] gated_word;

  assign top_byte  = large_variant_in ? `LARGE_TOP_BYTE
                                      : `SMALL_TOP_BYTE;
  // Config word n sits at top - 7 + 2n
  assign cfg_byte  = top_byte - 21'h000007 +
                     {18'h00000, cfg_step[`CONFIG_WORD_BITS-1:0], 1'b0};
  assign read_byte = cfg_busy ? cfg_byte : pc;
  assign implemented = (read_byte <= top_byte);

  prog_flash_array u_flash (
    .clk_in       (clk_in),
    .word_addr_in (read_byte[`LARGE_WORD_BITS:1]),
    .word_out     (flash_word),
    .prog_we_in   (prog_we_in),
    .prog_addr_in (prog_addr_in),
    .prog_data_in (prog_data_in)
  );

  // Flash word arrives one cycle after its address, so the range flag
  // is delayed with it; unimplemented space reads as a zero word.
  assign gated_word = implemented_q ? flash_word : 16'h0000;

  // Fetched word stands two cycles after the PC that addressed it.
  // Cycles that served the configuration copy are not reported.
  always @(posedge clk_in) begin
    if (srst_in) begin
      implemented_q  <= 1'b0;
      fetch_q        <= 1'b0;
      insn_out       <= 16'h0000;
      insn_valid_out <= 1'b0;
    end else begin
      implemented_q  <= implemented;
      fetch_q        <= !cfg_busy;
      insn_valid_out <= fetch_q;
      insn_out       <= fetch_q ? gated_word : 16'h0000;
    end
  end

  // Data space handshake never waits on the fetch path
  always @* begin
    data_ack_out = data_req_in;
  end

  // ------------------------------------------------------------
  // Configuration copy after reset
  // ------------------------------------------------------------
  reg [`CONFIG_WORD_BITS:0] cfg_prev;

  always @(posedge clk_in) begin
    if (srst_in) begin
      cfg_step        <= 3'h1;
      cfg_prev        <= 3'h0;
      config_data_out <= 64'h0000000000000000;
      config_done_out <= 1'b0;
    end else begin
      cfg_prev <= cfg_step;
      if (cfg_busy) begin
        cfg_step <= (cfg_step == 3'h4) ? 3'h0 : cfg_step + 3'h1;
      end
      if (cfg_prev != 3'h0) begin
        config_data_out[(cfg_prev[1:0])*`INSN_WIDTH +: `INSN_WIDTH] <=
          gated_word;
        if (cfg_prev == 3'h4) begin
          config_done_out <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Wake-up push onto the return stack
  // ------------------------------------------------------------
  // Saturates at the last entry rather than wrapping over live data.
  always @(posedge clk_in) begin
    if (srst_in) begin
      return_stack_pointer_out <= `STACK_PTR_RESET;
      stack_top_upper_byte_out <= 8'h00;
      stack_top_high_byte_out  <= 8'h00;
      stack_top_low_byte_out   <= 8'h00;
      push_strobe_out          <= 1'b0;
    end else begin
      push_strobe_out <= wake_vector;
      if (wake_vector) begin
        if (return_stack_pointer_out != `STACK_PTR_MAX) begin
          return_stack_pointer_out <= return_stack_pointer_out + 5'h01;
        end
        stack_top_upper_byte_out <= {3'h0, pc[20:16]};
        stack_top_high_byte_out  <= pc[15:8];
        stack_top_low_byte_out   <= pc[7:0];
      end
    end
  end

endmodule
`default_nettype wire

// ---- verification/prog_map_asserts.sv ----
// Port assertions for the program map block
`timescale 1ns/1ps
`default_nettype none
`include "prog_map_defines.vh"
module prog_map_asserts (
  input wire logic clk_in, srst_in, irq_wake_in, irq_high_in,
  input wire logic high_priority_global_irq_enable_in,
  input wire logic low_priority_global_irq_enable_in,
  input wire logic fetch_advance_in, pc_load_in, data_req_in,
  input wire logic data_ack_out, push_strobe_out, config_done_out,
  input wire logic [20:0] pc_load_value_in, pc_out,
  input wire logic [4:0] return_stack_pointer_out,
  input wire logic [7:0] stack_top_upper_byte_out,
  input wire logic [7:0] stack_top_high_byte_out, stack_top_low_byte_out
);
  wire logic [4:0] sp = return_stack_pointer_out;
  wire logic [20:0] tos = {stack_top_upper_byte_out[4:0],
    stack_top_high_byte_out, stack_top_low_byte_out};
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence wake;
    irq_wake_in && (high_priority_global_irq_enable_in ||
      low_priority_global_irq_enable_in);
  endsequence
  a_pc_even: assert property (pc_out[0] == 1'b0)
    else $error("pc odd");
  a_high_vector: assert property (wake ##0 irq_high_in |=>
    pc_out == `HIGH_IRQ_VECTOR) else $error("high vector");
  a_low_vector: assert property (wake ##0 !irq_high_in |=>
    pc_out == `LOW_IRQ_VECTOR) else $error("low vector");
  a_stack_push: assert property (wake ##0 sp != 5'h1f |=>
    push_strobe_out && tos == $past(pc_out) && sp == $past(sp) + 5'h01)
    else $error("push wrong");
  a_wake_ignored: assert property (irq_wake_in && !pc_load_in &&
    !fetch_advance_in && !high_priority_global_irq_enable_in &&
    !low_priority_global_irq_enable_in |=> $stable(pc_out) && $stable(sp))
    else $error("wake not ignored");
  a_pc_step: assert property (config_done_out && fetch_advance_in &&
    !pc_load_in && !irq_wake_in |=> pc_out == $past(pc_out) + `PC_STEP)
    else $error("step wrong");
  a_pc_load: assert property (pc_load_in && !irq_wake_in |=>
    pc_out == ($past(pc_load_value_in) & 21'h1ffffe)) else $error("load");
  a_data_ack: assert property (data_ack_out == data_req_in)
    else $error("data ack");
endmodule
`default_nettype wire

// ---- verification/core_model.sv ----
// Behavioural core that issues fetch and interrupt requests
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic clk_in,
  output logic fetch_advance_in, pc_load_in, irq_wake_in, irq_high_in,
  output logic high_priority_global_irq_enable_in,
  output logic low_priority_global_irq_enable_in,
  output logic [20:0] pc_load_value_in
);
  initial begin
    {fetch_advance_in, pc_load_in, irq_wake_in, irq_high_in} = 4'h0;
    high_priority_global_irq_enable_in = 1'b0;
    low_priority_global_irq_enable_in = 1'b0;
    pc_load_value_in = 21'h0;
  end
  // One request a cycle, set just after the edge so the block sees it next
  task automatic drive(input logic a, l, w, h, eh, el,
    input logic [20:0] v);
    @(posedge clk_in);
    #1 {fetch_advance_in, pc_load_in, irq_wake_in, irq_high_in} = {a, l, w, h};
    high_priority_global_irq_enable_in = eh;
    low_priority_global_irq_enable_in = el;
    pc_load_value_in = v;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the program map block
`timescale 1ns/1ps
`default_nettype none
`include "prog_map_defines.vh"
module tb;
  logic clk_in, srst_in, large_variant_in, prog_we_in, data_req_in;
  logic [15:0] prog_addr_in, prog_data_in;
  wire logic fetch_advance_in, pc_load_in, irq_wake_in, irq_high_in;
  wire logic high_priority_global_irq_enable_in;
  wire logic low_priority_global_irq_enable_in;
  wire logic data_ack_out, insn_valid_out, push_strobe_out, config_done_out;
  wire logic [20:0] pc_load_value_in, pc_out;
  wire logic [15:0] insn_out;
  wire logic [4:0] return_stack_pointer_out;
  wire logic [7:0] stack_top_upper_byte_out, stack_top_high_byte_out;
  wire logic [7:0] stack_top_low_byte_out;
  wire logic [63:0] config_data_out;
  wire logic [20:0] tos = {stack_top_upper_byte_out[4:0],
    stack_top_high_byte_out, stack_top_low_byte_out};
  int failures, checks;
  program_memory_map_vectoring DUT (.*);
  core_model core (.*);
  task check(input logic [63:0] got, exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task do_reset;
    @(posedge clk_in);
    #1 srst_in = 1'b1;
    repeat (12) @(posedge clk_in);
    #1 srst_in = 1'b0;
  endtask
  // Each check sees the request issued one call earlier
  task t_vectors;
    core.drive(0, 1, 0, 0, 0, 0, 21'h001235);
    core.drive(0, 0, 1, 1, 1, 0, 21'h0);
    check(pc_out, 21'h001234);
    data_req_in = 1'b1;
    core.drive(0, 0, 1, 0, 0, 1, 21'h0);
    check(data_ack_out, 1'b1);
    check({pc_out, tos, return_stack_pointer_out},
      {`HIGH_IRQ_VECTOR, 21'h001234, 5'h01});
    core.drive(0, 0, 1, 1, 0, 0, 21'h0);
    check({pc_out, tos, return_stack_pointer_out},
      {`LOW_IRQ_VECTOR, `HIGH_IRQ_VECTOR, 5'h02});
    repeat (2) core.drive(1, 0, 0, 0, 0, 0, 21'h0);
    core.drive(0, 0, 0, 0, 0, 0, 21'h0);
    check(pc_out, `LOW_IRQ_VECTOR + 21'h4);
    data_req_in = 1'b0;
  endtask
  // Writes the top four words, then a reset must copy them out
  task t_config(input logic v);
    logic [15:0] b;
    b = {8'hc0, 3'h0, v, 4'h0};
    large_variant_in = v;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      #1 prog_we_in = 1'b1;
      prog_addr_in = {v, 15'h7ffc} + 16'(i);
      prog_data_in = b + 16'(i);
      @(posedge clk_in);
      #1 prog_we_in = 1'b0;
    end
    do_reset;
    check({pc_out, return_stack_pointer_out, config_done_out}, 0);
    for (int n = 0; n < 20 && config_done_out !== 1'b1; n++)
      @(posedge clk_in);
    #1 check(config_data_out, {b + 16'h3, b + 16'h2, b + 16'h1, b});
  endtask
  // Large part: two words inside memory, then one above its top
  task t_fetch;
    core.drive(0, 1, 0, 0, 0, 0, 21'h01fff8);
    repeat (3) core.drive(0, 0, 0, 0, 0, 0, 21'h0);
    check({insn_valid_out, insn_out}, {1'b1, 16'hc010});
    core.drive(0, 1, 0, 0, 0, 0, 21'h00fff8);
    repeat (3) core.drive(0, 0, 0, 0, 0, 0, 21'h0);
    check({insn_valid_out, insn_out}, {1'b1, 16'hc000});
    core.drive(0, 1, 0, 0, 0, 0, 21'h020000);
    repeat (3) core.drive(0, 0, 0, 0, 0, 0, 21'h0);
    check({insn_valid_out, insn_out}, {1'b1, 16'h0000});
  endtask
  task complete_run;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    {srst_in, large_variant_in, prog_we_in, data_req_in} = 4'h8;
    {prog_addr_in, prog_data_in} = 32'h0;
    do_reset;
    t_config(1'b0);
    t_vectors;
    t_config(1'b1);
    t_fetch;
    complete_run;
  end
  initial begin
    repeat (2000) @(posedge clk_in);
    failures++;
    complete_run;
  end
endmodule
bind program_memory_map_vectoring prog_map_asserts checker_i (.*);
`default_nettype wire
